/* logic/mdpc_core.sv */
`timescale 1ns/1ps
// Pin-level control of a microprogrammable 16-bit datapath slice.
module mdpc_core #(
  parameter int WORD_W = mdpc_pkg::WORD_W,
  parameter int ADDR_W = mdpc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // Datapath clock pin and control inputs
  input  wire logic              sys_clock_in,
  input  wire logic              instr_enable_n_in,
  input  wire logic              status_update_gate_n_in,
  input  wire logic              in_latch_open_in,
  input  wire logic [WORD_W-1:0] microword_in,
  // Flag port
  input  wire logic              flag_port_oe_in,
  input  wire logic [3:0]        flag_port_in,
  output logic      [3:0]        flag_port_out,
  output logic                   flag_port_oe_out,
  // Data bus
  input  wire logic              data_bus_oe_n_in,
  input  wire logic [WORD_W-1:0] data_bus_in,
  output logic      [WORD_W-1:0] data_bus_out,
  output logic                   data_bus_oe_out,
  // Condition result
  output logic                   cond_pass_out
);

  // The field layout is fixed at 16 bits with a 32-word register file.
  if (WORD_W != mdpc_pkg::WORD_W || ADDR_W != mdpc_pkg::ADDR_W)
    $error("mdpc_core supports only a 16-bit word and 5-bit address");

  localparam int RAM_WORDS = 1 << ADDR_W;

  // Merges a new value into an old one, low byte only in byte mode.
  function automatic logic [15:0] merge_w(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic        byte_m);
    merge_w = byte_m ? {old_v[15:8], new_v[7:0]} : new_v;
  endfunction : merge_w

  // Rising-edge and phase tracking of the datapath clock pin.
  logic clk_pin_q;
  logic clk_pin_d;
  logic rise;

  // Instruction latch state.
  logic        imm_q;
  logic        imm_d;
  logic [15:0] instr_hold_q;
  logic [15:0] instr_hold_d;

  // Storage elements.
  logic [15:0] ram_mem [RAM_WORDS];
  logic [15:0] ram_lat_q;
  logic [15:0] ram_lat_d;
  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [7:0]  stat_q;
  logic [7:0]  stat_d;
  logic [15:0] dlat_q;
  logic [15:0] dlat_d;
  logic [3:0]  sel_q;
  logic [3:0]  sel_d;

  // Output flip-flops.
  logic [3:0]  flag_out_d;
  logic        flag_oe_d;
  logic [15:0] bus_out_d;
  logic        bus_oe_d;
  logic        pass_d;

  // Decoded instruction and datapath results.
  logic [15:0] instr;
  logic [2:0]  cls;
  logic [1:0]  dest;
  logic [1:0]  src;
  logic [1:0]  op;
  logic        byte_m;
  logic [4:0]  addr;
  logic        exec;
  logic [15:0] operand;
  logic [15:0] result;
  logic [3:0]  alu_flags;
  logic        ram_we;
  logic [15:0] ram_wdata;

  mdpc_cond_if cond ();

  mdpc_cond_mux u_cond (
    .cond (cond.mux)
  );

  assign rise = sys_clock_in & ~clk_pin_q;

  // Instruction latch: transparent, or holding the opcode of an immediate.
  always_comb
  begin
    instr  = imm_q ? instr_hold_q : microword_in;
    cls    = instr[mdpc_pkg::CLASS_HI:mdpc_pkg::CLASS_LO];
    dest   = instr[mdpc_pkg::DEST_HI:mdpc_pkg::DEST_LO];
    src    = instr[mdpc_pkg::SRC_HI:mdpc_pkg::SRC_LO];
    op     = instr[mdpc_pkg::OP_HI:mdpc_pkg::OP_LO];
    byte_m = instr[mdpc_pkg::BYTE_BIT];
    addr   = instr[mdpc_pkg::ADDR_LO +: 5];
    // The first cycle of an immediate only fetches; the second one executes.
    exec   = imm_q || cls != mdpc_pkg::CLS_IMM;
  end

  // Operand selection and a small ALU with byte or word flags.
  always_comb
  begin
    logic [16:0] sum;
    logic        cin;
    logic        msb;
    logic        cout;
    logic        amsb;
    logic        bmsb;
    sum  = 17'h00000;
    cin  = 1'b0;
    msb  = 1'b0;
    cout = 1'b0;
    amsb = 1'b0;
    bmsb = 1'b0;
    unique case (src)
      mdpc_pkg::SRC_RAM:  operand = ram_lat_q;
      mdpc_pkg::SRC_ACC:  operand = acc_q;
      mdpc_pkg::SRC_DLAT: operand = dlat_q;
      mdpc_pkg::SRC_STAT: operand = {8'h00, stat_q};
    endcase
    if (imm_q)
    begin
      operand = microword_in;
    end
    cin  = (op == mdpc_pkg::OP_ADDC) ? stat_q[mdpc_pkg::ST_C] : 1'b0;
    sum  = {1'b0, operand} + {1'b0, acc_q} + {16'h0000, cin};
    unique case (op)
      mdpc_pkg::OP_PASS: result = operand;
      mdpc_pkg::OP_ADD:  result = sum[15:0];
      mdpc_pkg::OP_ADDC: result = sum[15:0];
      mdpc_pkg::OP_AND:  result = operand & acc_q;
    endcase
    if (cls == mdpc_pkg::CLS_SAVE)
    begin
      result = {8'h00, stat_q};
    end
    msb  = byte_m ? result[7] : result[15];
    amsb = byte_m ? operand[7] : operand[15];
    bmsb = byte_m ? acc_q[7] : acc_q[15];
    cout = byte_m ? (operand[8] ^ acc_q[8] ^ sum[8]) : sum[16];
    if (op == mdpc_pkg::OP_ADD || op == mdpc_pkg::OP_ADDC)
    begin
      alu_flags[mdpc_pkg::ST_C]   = cout;
      alu_flags[mdpc_pkg::ST_OVR] = (amsb == bmsb) && (msb != amsb);
    end
    else
    begin
      alu_flags[mdpc_pkg::ST_C]   = 1'b0;
      alu_flags[mdpc_pkg::ST_OVR] = 1'b0;
    end
    alu_flags[mdpc_pkg::ST_N] = msb;
    alu_flags[mdpc_pkg::ST_Z] = byte_m ? (result[7:0] == 8'h00) : (result == 16'h0000);
  end

  // Register file write during the low phase of the clock pin.
  always_comb
  begin
    ram_we    = ~sys_clock_in && ~instr_enable_n_in && exec &&
                dest == mdpc_pkg::DST_RAM &&
                cls inside {mdpc_pkg::CLS_NORMAL, mdpc_pkg::CLS_IMM,
                            mdpc_pkg::CLS_SAVE};
    ram_wdata = merge_w(ram_mem[addr], result, byte_m);
  end

  // The register file itself has no reset.
  always_ff @(posedge clk_in)
  begin
    if (ram_we)
    begin
      ram_mem[addr] <= ram_wdata;
    end
  end

  // Next values of the latches, accumulator, status and selector.
  always_comb
  begin
    logic stat_ok;
    logic acc_ok;
    stat_ok      = 1'b0;
    acc_ok       = 1'b0;
    clk_pin_d    = sys_clock_in;
    imm_d        = imm_q;
    instr_hold_d = instr_hold_q;
    ram_lat_d    = ram_lat_q;
    acc_d        = acc_q;
    stat_d       = stat_q;
    dlat_d       = dlat_q;
    sel_d        = sel_q;
    if (sys_clock_in)
    begin
      ram_lat_d = ram_mem[addr];
    end
    if (in_latch_open_in)
    begin
      dlat_d = data_bus_oe_n_in ? data_bus_in : result;
    end
    // Immediate mode is entered and left only on rising edges.
    if (rise)
    begin
      if (imm_q)
      begin
        imm_d = 1'b0;
      end
      else if (cls == mdpc_pkg::CLS_IMM && ~instr_enable_n_in)
      begin
        imm_d        = 1'b1;
        instr_hold_d = microword_in;
      end
    end
    acc_ok  = rise && ~instr_enable_n_in && exec;
    stat_ok = acc_ok && ~status_update_gate_n_in;
    if (acc_ok && dest == mdpc_pkg::DST_ACC &&
        cls inside {mdpc_pkg::CLS_NORMAL, mdpc_pkg::CLS_IMM, mdpc_pkg::CLS_SAVE})
    begin
      acc_d = merge_w(acc_q, result, byte_m);
    end
    if (stat_ok)
    begin
      unique case (cls)
        mdpc_pkg::CLS_NORMAL, mdpc_pkg::CLS_IMM:
        begin
          stat_d[3:0] = alu_flags;
        end
        mdpc_pkg::CLS_UFLAG:
        begin
          stat_d[7:4] = instr[mdpc_pkg::UFLAG_LO +: 4];
        end
        mdpc_pkg::CLS_LOAD:
        begin
          stat_d = byte_m ? {stat_q[7:4], result[3:0]} : result[7:0];
        end
        mdpc_pkg::CLS_NOP, mdpc_pkg::CLS_SAVE, mdpc_pkg::CLS_TEST:
        begin
          stat_d = stat_q;
        end
        default:
        begin
          stat_d = stat_q;
        end
      endcase
    end
    // The selector only follows the microword while instructions are enabled.
    if (~instr_enable_n_in && ~imm_q && cls == mdpc_pkg::CLS_TEST)
    begin
      sel_d = instr[mdpc_pkg::SEL_LO +: 4];
    end
  end

  // Condition inputs come from the flag pins when the port is not driven.
  always_comb
  begin
    cond.zcnv = flag_port_oe_in ? stat_q[3:0] : flag_port_in;
    cond.sel  = sel_q;
  end

  // Next values of the output flip-flops.
  always_comb
  begin
    pass_d     = cond.pass;
    flag_out_d = stat_q[3:0];
    flag_oe_d  = ~flag_port_oe_in;
    bus_out_d  = result;
    bus_oe_d   = data_bus_oe_n_in;
  end

  // All registers but the register file; the synchronous reset clears them, except clk_pin_q and both pin enables, which load 1.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      clk_pin_q        <= 1'b1;  // Idle pin level, so no false rise follows reset.
      imm_q            <= 1'b0;
      instr_hold_q     <= mdpc_pkg::WORD_RST;
      ram_lat_q        <= mdpc_pkg::WORD_RST;
      acc_q            <= mdpc_pkg::WORD_RST;
      stat_q           <= mdpc_pkg::STATUS_RST;
      dlat_q           <= mdpc_pkg::WORD_RST;
      sel_q            <= mdpc_pkg::SEL_RST;
      cond_pass_out    <= 1'b0;
      flag_port_out    <= 4'h0;
      flag_port_oe_out <= 1'b1;
      data_bus_out     <= mdpc_pkg::WORD_RST;
      data_bus_oe_out  <= 1'b1;
    end
    else
    begin
      clk_pin_q        <= clk_pin_d;
      imm_q            <= imm_d;
      instr_hold_q     <= instr_hold_d;
      ram_lat_q        <= ram_lat_d;
      acc_q            <= acc_d;
      stat_q           <= stat_d;
      dlat_q           <= dlat_d;
      sel_q            <= sel_d;
      cond_pass_out    <= pass_d;
      flag_port_out    <= flag_out_d;
      flag_port_oe_out <= flag_oe_d;
      data_bus_out     <= bus_out_d;
      data_bus_oe_out  <= bus_oe_d;
    end
  end

endmodule : mdpc_core

/* shared/mdpc_pkg.sv */
package mdpc_pkg;

  // Datapath sizes.
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 5;
  localparam int STATUS_W  = 8;
  localparam int FLAG_W    = 4;
  localparam int SEL_W     = 4;
  localparam int NUM_COND  = 12;

  // Microword fields.
  localparam int CLASS_HI  = 15;
  localparam int CLASS_LO  = 13;
  localparam int DEST_HI   = 12;
  localparam int DEST_LO   = 11;
  localparam int SRC_HI    = 10;
  localparam int SRC_LO    = 9;
  localparam int OP_HI     = 8;
  localparam int OP_LO     = 7;
  localparam int BYTE_BIT  = 6;
  localparam int ADDR_LO   = 0;
  localparam int SEL_LO    = 0;
  localparam int UFLAG_LO  = 5;

  // Instruction classes.
  localparam logic [2:0] CLS_NORMAL = 3'h0;
  localparam logic [2:0] CLS_IMM    = 3'h1;
  localparam logic [2:0] CLS_NOP    = 3'h2;
  localparam logic [2:0] CLS_SAVE   = 3'h3;
  localparam logic [2:0] CLS_TEST   = 3'h4;
  localparam logic [2:0] CLS_UFLAG  = 3'h5;
  localparam logic [2:0] CLS_LOAD   = 3'h6;

  // Destinations.
  localparam logic [1:0] DST_NONE = 2'h0;
  localparam logic [1:0] DST_RAM  = 2'h1;
  localparam logic [1:0] DST_ACC  = 2'h2;
  localparam logic [1:0] DST_BUS  = 2'h3;

  // Operand sources.
  localparam logic [1:0] SRC_RAM  = 2'h0;
  localparam logic [1:0] SRC_ACC  = 2'h1;
  localparam logic [1:0] SRC_DLAT = 2'h2;
  localparam logic [1:0] SRC_STAT = 2'h3;

  // Operations.
  localparam logic [1:0] OP_PASS  = 2'h0;
  localparam logic [1:0] OP_ADD   = 2'h1;
  localparam logic [1:0] OP_ADDC  = 2'h2;
  localparam logic [1:0] OP_AND   = 2'h3;

  // Status bit positions.
  localparam int ST_Z   = 0;
  localparam int ST_C   = 1;
  localparam int ST_N   = 2;
  localparam int ST_OVR = 3;

  // Reset values.
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [3:0]  SEL_RST    = 4'h0;

endpackage : mdpc_pkg

/* shared/mdpc_cond_if.sv */
`timescale 1ns/1ps
// Carries the condition inputs and selection to the condition multiplexer.
interface mdpc_cond_if;
  logic [3:0] zcnv;
  logic [3:0] sel;
  logic       pass;

  modport core (output zcnv, output sel, input pass);
  modport mux  (input zcnv, input sel, output pass);
endinterface : mdpc_cond_if

/* logic/mdpc_cond_mux.sv */
`timescale 1ns/1ps
// Forms the twelve condition signals and selects one of them.
module mdpc_cond_mux (
  // Condition carrier
  mdpc_cond_if.mux cond
);

  // One bit per condition; unused selector codes read as a fail.
  always_comb
  begin
    logic z;
    logic c;
    logic n;
    logic v;
    z = cond.zcnv[mdpc_pkg::ST_Z];
    c = cond.zcnv[mdpc_pkg::ST_C];
    n = cond.zcnv[mdpc_pkg::ST_N];
    v = cond.zcnv[mdpc_pkg::ST_OVR];
    unique case (cond.sel)
      4'h0:    cond.pass = z;
      4'h1:    cond.pass = ~z;
      4'h2:    cond.pass = c;
      4'h3:    cond.pass = ~c;
      4'h4:    cond.pass = n;
      4'h5:    cond.pass = ~n;
      4'h6:    cond.pass = v;
      4'h7:    cond.pass = ~v;
      4'h8:    cond.pass = n ^ v;
      4'h9:    cond.pass = ~(n ^ v);
      4'ha:    cond.pass = z | (n ^ v);
      4'hb:    cond.pass = ~z & ~c;
      default: cond.pass = 1'b0;
    endcase
  end

endmodule : mdpc_cond_mux

/* testbench/mdpc_seq_model.sv */
`timescale 1ns/1ps
// Sequencer stand-in: presents microwords and paces the datapath clock pin.
module mdpc_seq_model (
  // Clock
  input  wire logic   clk_in,
  // Sequencer outputs
  output logic        sys_clock_out,
  output logic        instr_enable_n_out,
  output logic [15:0] microword_out
);
  // Idle with the clock pin high and the instruction enable inactive.
  initial
  begin
    sys_clock_out      = 1'b1;
    instr_enable_n_out = 1'b1;
    microword_out      = 16'h0000;
  end

  // One datapath cycle: two clocks with the pin low, then two with it high.
  task automatic run(input logic [15:0] word, input logic ien_n);
    @(negedge clk_in);
    sys_clock_out      = 1'b0;
    instr_enable_n_out = ien_n;
    microword_out      = word;
    repeat (2) @(negedge clk_in);
    sys_clock_out = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask : run
endmodule : mdpc_seq_model

/* testbench/mdpc_core_sva.sv */
`timescale 1ns/1ps
// Watches the pins of the datapath slice.
module mdpc_core_chk #(
  parameter int WORD_W = mdpc_pkg::WORD_W
) (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  // Control inputs
  input wire logic              sys_clock_in,
  input wire logic              instr_enable_n_in,
  input wire logic              status_update_gate_n_in,
  input wire logic              in_latch_open_in,
  input wire logic [WORD_W-1:0] microword_in,
  // Flag port
  input wire logic              flag_port_oe_in,
  input wire logic [3:0]        flag_port_in,
  input wire logic [3:0]        flag_port_out,
  input wire logic              flag_port_oe_out,
  // Data bus and condition
  input wire logic              data_bus_oe_n_in,
  input wire logic [WORD_W-1:0] data_bus_in,
  input wire logic [WORD_W-1:0] data_bus_out,
  input wire logic              data_bus_oe_out,
  input wire logic              cond_pass_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Pin enables follow their inputs one clock later, the flag port enable inverted.
  flag_oe_a: assert property (!$past(sys_rst_in) |-> flag_port_oe_out == !$past(flag_port_oe_in))
    else $error("flag port enable wrong");
  bus_oe_a: assert property (!$past(sys_rst_in) |-> data_bus_oe_out == $past(data_bus_oe_n_in))
    else $error("data bus enable wrong");
  bus_drive_a: assert property (!data_bus_oe_n_in [*3] |=> !data_bus_oe_out)
    else $error("data bus not driven");
  // Status and condition freeze while gated.
  cond_frozen_a: assert property ((instr_enable_n_in && $past(instr_enable_n_in)
    && $past(instr_enable_n_in, 2) && $stable(flag_port_in) && $stable(flag_port_oe_in)
    && !$past(sys_rst_in)) |=> $stable(cond_pass_out))
    else $error("pass output moved while disabled");
  status_gate_a: assert property ((status_update_gate_n_in || instr_enable_n_in)
    |=> ##1 $stable(flag_port_out))
    else $error("status changed while gated");
  status_edge_a: assert property ((!$past(sys_rst_in) && !$past(sys_rst_in, 2)
    && flag_port_out != $past(flag_port_out)) |-> ($past(sys_clock_in, 2)
    && !$past(sys_clock_in, 3) && !$past(instr_enable_n_in, 2)
    && !$past(status_update_gate_n_in, 2)))
    else $error("status changed off a clock pin rise");
  // Result holds when nothing feeding it can move.
  result_hold_a: assert property ((instr_enable_n_in && $past(instr_enable_n_in)
    && $stable(microword_in) && $stable(data_bus_in) && $stable(data_bus_oe_n_in)
    && !in_latch_open_in && !$past(in_latch_open_in) && !sys_clock_in
    && !$past(sys_clock_in) && !$past(sys_rst_in)) |=> $stable(data_bus_out))
    else $error("result moved with latches holding");
  reset_vals_a: assert property (disable iff (1'b0) sys_rst_in |=> (data_bus_oe_out
    && flag_port_oe_out && !cond_pass_out && data_bus_out == '0 && flag_port_out == 4'h0))
    else $error("reset values wrong");
endmodule : mdpc_core_chk

bind mdpc_core mdpc_core_chk #(.WORD_W(WORD_W)) chk_u (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .sys_clock_in(sys_clock_in),
  .instr_enable_n_in(instr_enable_n_in), .status_update_gate_n_in(status_update_gate_n_in),
  .in_latch_open_in(in_latch_open_in), .microword_in(microword_in),
  .flag_port_oe_in(flag_port_oe_in), .flag_port_in(flag_port_in),
  .flag_port_out(flag_port_out), .flag_port_oe_out(flag_port_oe_out),
  .data_bus_oe_n_in(data_bus_oe_n_in), .data_bus_in(data_bus_in),
  .data_bus_out(data_bus_out), .data_bus_oe_out(data_bus_oe_out),
  .cond_pass_out(cond_pass_out));

/* testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the datapath slice pin control.
module tb;
  // Bench drives, pin wires and counters.
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        sre_n = 1'b1;
  logic        latch_open = 1'b0;
  logic        flag_oe = 1'b0;
  logic [3:0]  flag_pins = 4'h0;
  logic        bus_oe_n = 1'b1;
  logic [15:0] bus_pins = 16'h0000;
  logic        sys_clock;
  logic        ien_n;
  logic [15:0] mword;
  logic [3:0]  flag_out;
  logic        flag_oe_out;
  logic [15:0] bus_out;
  logic        bus_oe_out;
  logic        pass;
  int          err_count = 0;
  int          total_checks = 0;

  // The 100 ns clock.
  always #50 clk_in = ~clk_in;

  mdpc_seq_model seq_u (.clk_in(clk_in), .sys_clock_out(sys_clock),
    .instr_enable_n_out(ien_n), .microword_out(mword));

  // Shared pins take the design's value only while it drives them.
  mdpc_core dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sys_clock_in(sys_clock),
    .instr_enable_n_in(ien_n), .status_update_gate_n_in(sre_n),
    .in_latch_open_in(latch_open), .microword_in(mword), .flag_port_oe_in(flag_oe),
    .flag_port_in(flag_oe_out ? flag_pins : flag_out), .flag_port_out(flag_out),
    .flag_port_oe_out(flag_oe_out), .data_bus_oe_n_in(bus_oe_n),
    .data_bus_in(bus_oe_out ? bus_pins : bus_out), .data_bus_out(bus_out),
    .data_bus_oe_out(bus_oe_out), .cond_pass_out(pass));

  function automatic logic [15:0] mw(input logic [2:0] c, input logic [1:0] d,
                                     input logic [1:0] s, input logic b, input logic [4:0] a);
    return {c, d, s, mdpc_pkg::OP_PASS, b, 1'b0, a};
  endfunction : mw

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask : check

  // Loads a bus value through the data latch into a destination.
  task automatic load(input logic [15:0] v, input logic [1:0] d, input logic b,
                      input logic [4:0] a, input logic instr_enable_n);
    @(negedge clk_in);
    bus_oe_n   = 1'b1;
    latch_open = 1'b1;
    bus_pins   = v;
    seq_u.run(mw(mdpc_pkg::CLS_NORMAL, d, mdpc_pkg::SRC_DLAT, b, a), instr_enable_n);
    latch_open = 1'b0;
  endtask : load

  // Shows a source on the driven bus with status updates gated off.
  task automatic show(input logic [1:0] s, input logic [4:0] a, input logic [15:0] e,
                      input string nm);
    bus_oe_n = 1'b0;
    sre_n    = 1'b1;
    seq_u.run(mw(mdpc_pkg::CLS_NORMAL, mdpc_pkg::DST_NONE, s, 1'b0, a), 1'b0);
    check(nm, bus_out, e);
  endtask : show

  task automatic t_reset();
    @(negedge clk_in);
    check("reset bus", bus_out, 16'h0000);
    check("reset enables", 16'({bus_oe_out, flag_oe_out, pass}), 16'h0006);
    $display("test reset done");
  endtask : t_reset

  task automatic t_oe();
    flag_oe  = 1'b1;
    bus_oe_n = 1'b0;
    repeat (2) @(negedge clk_in);
    check("enables on", 16'({bus_oe_out, flag_oe_out}), 16'h0000);
    flag_oe  = 1'b0;
    bus_oe_n = 1'b1;
    repeat (2) @(negedge clk_in);
    check("enables off", 16'({bus_oe_out, flag_oe_out}), 16'h0003);
    $display("test enables done");
  endtask : t_oe

  task automatic t_acc();
    sre_n = 1'b0;
    load(16'h8001, mdpc_pkg::DST_ACC, 1'b0, 5'h00, 1'b0);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h8001, "acc");
    check("flags", 16'(flag_out), 16'h0004);
    sre_n = 1'b0;
    load(16'h1234, mdpc_pkg::DST_ACC, 1'b0, 5'h00, 1'b1);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h8001, "acc held");
    load(16'h0000, mdpc_pkg::DST_ACC, 1'b0, 5'h00, 1'b0);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h0000, "acc zero");
    check("flags gated", 16'(flag_out), 16'h0004);
    $display("test accumulator done");
  endtask : t_acc

  task automatic t_imm();
    seq_u.run(mw(mdpc_pkg::CLS_IMM, mdpc_pkg::DST_ACC, mdpc_pkg::SRC_RAM, 1'b0, 5'h00), 1'b0);
    seq_u.run(16'h5a5a, 1'b0);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h5a5a, "imm acc");
    load(16'habcd, mdpc_pkg::DST_ACC, 1'b1, 5'h00, 1'b0);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h5acd, "byte acc");
    $display("test immediate done");
  endtask : t_imm

  task automatic t_ram();
    load(16'hc3c3, mdpc_pkg::DST_RAM, 1'b0, 5'h03, 1'b0);
    load(16'h0f0f, mdpc_pkg::DST_RAM, 1'b0, 5'h03, 1'b1);
    show(mdpc_pkg::SRC_RAM, 5'h03, 16'hc3c3, "ram");
    load(16'h00aa, mdpc_pkg::DST_RAM, 1'b1, 5'h03, 1'b0);
    show(mdpc_pkg::SRC_RAM, 5'h03, 16'hc3aa, "ram byte");
    $display("test register file done");
  endtask : t_ram

  // Flag pins Z,C,N,V in bits 0..3; one expected bit for each select code.
  task automatic t_cond();
    logic [3:0]  pat [2];
    logic [15:0] exp [2];
    pat = '{4'h5, 4'ha};
    exp = '{16'h0599, 16'h0566};
    sre_n = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      flag_pins = pat[p];
      for (int c = 0; c < 16; c++)
      begin
        seq_u.run(mw(mdpc_pkg::CLS_TEST, 2'h0, mdpc_pkg::SRC_ACC, 1'b0, 5'(c)), 1'b0);
        check("cond", 16'(pass), 16'(exp[p][c]));
      end
    end
    flag_pins = 4'h5;
    seq_u.run(mw(mdpc_pkg::CLS_TEST, 2'h0, mdpc_pkg::SRC_ACC, 1'b0, 5'h00), 1'b0);
    seq_u.run(mw(mdpc_pkg::CLS_TEST, 2'h0, mdpc_pkg::SRC_ACC, 1'b0, 5'h01), 1'b1);
    check("cond frozen", 16'(pass), 16'h0001);
    check("test keeps status", 16'(flag_out), 16'h0004);
    $display("test condition done");
  endtask : t_cond

  // Adds a bus value to the accumulator, then saves the status into it.
  task automatic t_ops();
    sre_n = 1'b0;
    @(negedge clk_in);
    bus_oe_n   = 1'b1;
    latch_open = 1'b1;
    bus_pins   = 16'ha533;
    seq_u.run(mw(mdpc_pkg::CLS_NORMAL, mdpc_pkg::DST_ACC, mdpc_pkg::SRC_DLAT, 1'b0, 5'h00) |
              (16'(mdpc_pkg::OP_ADD) << mdpc_pkg::OP_LO), 1'b0);
    latch_open = 1'b0;
    check("add flags", 16'(flag_out), 16'h0003);
    seq_u.run(mw(mdpc_pkg::CLS_SAVE, mdpc_pkg::DST_ACC, mdpc_pkg::SRC_ACC, 1'b0, 5'h00), 1'b0);
    show(mdpc_pkg::SRC_ACC, 5'h00, 16'h0003, "saved status");
    check("save keeps status", 16'(flag_out), 16'h0003);
    $display("test operations done");
  endtask : t_ops

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Main sequence after five clocks of reset.
  initial
  begin
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_oe();
    t_acc();
    t_imm();
    t_ram();
    t_cond();
    t_ops();
    finish_test();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    finish_test();
  end
endmodule : tb
